// *** inc/srseq_pkg.sv ***
// constants and types for the staged subsystem reset sequencer
// assumes a single 40 MHz system clock and a synchronous active-low core reset
package srseq_pkg;
  // board request must be stable this many clocks before it counts
  localparam int unsigned FILT_LEN = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] STAGE_GAP = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [2:0] FILT_ALL_ONE = 3'h7;
  localparam logic [2:0] FILT_ALL_ZERO = 3'h0;

  typedef enum logic [1:0] {
    SR_HOLD,
    SR_BUS,
    SR_PERIPH,
    SR_DONE
  } srseq_state_t;
endpackage : srseq_pkg

// *** logic/srseq_top.sv ***
// staged reset generator: interconnect, then peripherals, then processor
// assumes boardRst is asynchronous to core_clk and reset targets sample on core_clk
module srseq_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic boardRst,
  output logic busRstn,
  output logic periphRstn,
  output logic cpuRstn
);

  logic sync1_r;
  logic sync2_r;
  logic [srseq_pkg::FILT_LEN-2:0] filtHist_r;
  logic reqFilt_r;
  srseq_pkg::srseq_state_t state_r;
  logic [srseq_pkg::CNT_W-1:0] gapCnt_r;

  // two-stage synchroniser; only sync2_r is read by logic
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= boardRst;
      sync2_r <= sync1_r;
    end
  end

  // glitch filter: level changes only after FILT_LEN equal samples
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      filtHist_r <= srseq_pkg::FILT_ALL_ONE;
      reqFilt_r <= 1'b1;
    end
    else
    begin
      filtHist_r <= {filtHist_r[srseq_pkg::FILT_LEN-3:0], sync2_r};
      if (sync2_r && filtHist_r == srseq_pkg::FILT_ALL_ONE)
      begin
        reqFilt_r <= 1'b1;
      end
      else if (!sync2_r && filtHist_r == srseq_pkg::FILT_ALL_ZERO)
      begin
        reqFilt_r <= 1'b0;
      end
    end
  end

  // sequence state; a request anywhere drops back to hold
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_r <= srseq_pkg::SR_HOLD;
      gapCnt_r <= srseq_pkg::CNT_ZERO;
    end
    else if (reqFilt_r)
    begin
      state_r <= srseq_pkg::SR_HOLD;
      gapCnt_r <= srseq_pkg::CNT_ZERO;
    end
    else
    begin
      unique case (state_r)
        srseq_pkg::SR_HOLD:
        begin
          state_r <= srseq_pkg::SR_BUS;
          gapCnt_r <= srseq_pkg::CNT_ONE;
        end
        srseq_pkg::SR_BUS:
        begin
          if (gapCnt_r == srseq_pkg::STAGE_GAP)
          begin
            state_r <= srseq_pkg::SR_PERIPH;
            gapCnt_r <= srseq_pkg::CNT_ONE;
          end
          else
          begin
            gapCnt_r <= gapCnt_r + srseq_pkg::CNT_ONE;
          end
        end
        srseq_pkg::SR_PERIPH:
        begin
          if (gapCnt_r == srseq_pkg::STAGE_GAP)
          begin
            state_r <= srseq_pkg::SR_DONE;
            gapCnt_r <= srseq_pkg::CNT_ZERO;
          end
          else
          begin
            gapCnt_r <= gapCnt_r + srseq_pkg::CNT_ONE;
          end
        end
        srseq_pkg::SR_DONE:
        begin
          gapCnt_r <= srseq_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // outputs registered; low holds the target in reset
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      busRstn <= 1'b0;
      periphRstn <= 1'b0;
      cpuRstn <= 1'b0;
    end
    else
    begin
      busRstn <= !reqFilt_r && state_r != srseq_pkg::SR_HOLD;
      periphRstn <= !reqFilt_r && (state_r == srseq_pkg::SR_PERIPH
        || state_r == srseq_pkg::SR_DONE);
      cpuRstn <= !reqFilt_r && state_r == srseq_pkg::SR_DONE;
    end
  end

  chk_bus_first: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(periphRstn) |-> $past(busRstn, 16))
    else $error("peripheral left reset without bus 16 clocks earlier");

  chk_periph_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(busRstn) && !reqFilt_r) ##1 (!reqFilt_r)[*8] ##1 (!reqFilt_r)[*7]
      |=> $rose(periphRstn))
    else $error("peripheral release not 16 clocks after bus release");

  chk_cpu_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cpuRstn) |-> periphRstn && $past(periphRstn, 16) && !$past(periphRstn, 17))
    else $error("processor release not 16 clocks after peripheral release");

  chk_cpu_last: assert property (@(posedge core_clk) disable iff (!rstn)
    cpuRstn |-> periphRstn && busRstn)
    else $error("processor out of reset before others");

  chk_req_holds: assert property (@(posedge core_clk) disable iff (!rstn)
    reqFilt_r |=> !busRstn && !periphRstn && !cpuRstn)
    else $error("outputs released while request active");

  chk_req_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    reqFilt_r ##1 !reqFilt_r |-> state_r == srseq_pkg::SR_HOLD)
    else $error("sequence did not restart after request");

  chk_glitch_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    !reqFilt_r && !sync2_r ##1 sync2_r ##1 !sync2_r |=> !reqFilt_r)
    else $error("short glitch reached filtered request");

  chk_sync_delay: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(reqFilt_r) |-> $past(sync2_r, 1) && $past(sync2_r, 4))
    else $error("filtered request rose without stable synchronised input");

  // checker-only helpers: previous output levels and cycles since the latest bus or peripheral release;
  // kept apart from gapCnt_r so the gap checks cannot share a slip with the sequencer
  logic busPrev_r;
  logic periphPrev_r;
  logic [srseq_pkg::CNT_W-1:0] stageAge_r;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      busPrev_r <= 1'b0;
      periphPrev_r <= 1'b0;
    end
    else
    begin
      busPrev_r <= busRstn;
      periphPrev_r <= periphRstn;
    end
  end

  // saturates one past the gap so a late release still shows as a wrong age
  always_ff @(posedge core_clk)
  begin
    if (!rstn || !busRstn)
    begin
      stageAge_r <= srseq_pkg::CNT_ZERO;
    end
    else if ((busRstn && !busPrev_r) || (periphRstn && !periphPrev_r))
    begin
      stageAge_r <= srseq_pkg::CNT_ONE;
    end
    else if (stageAge_r != srseq_pkg::STAGE_GAP + srseq_pkg::CNT_ONE)
    begin
      stageAge_r <= stageAge_r + srseq_pkg::CNT_ONE;
    end
  end

  chk_out_reset: assert property (@(posedge core_clk)
    !rstn |=> !busRstn && !periphRstn && !cpuRstn)
    else $error("reset outputs not held low during core reset");

  chk_bus_release: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(reqFilt_r) ##1 !reqFilt_r |=> $rose(busRstn))
    else $error("bus reset not released first after request cleared");

  chk_bus_order: assert property (@(posedge core_clk) disable iff (!rstn)
    periphRstn |-> busRstn)
    else $error("peripheral out of reset while bus still held");

  chk_periph_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(busRstn) |-> (!periphRstn)[*8] ##1 (!periphRstn)[*8])
    else $error("peripheral released early after bus release");

  chk_periph_age: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(periphRstn) |-> stageAge_r == srseq_pkg::STAGE_GAP)
    else $error("peripheral release age differs from stage gap");

  chk_cpu_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(periphRstn) |-> (!cpuRstn)[*8] ##1 (!cpuRstn)[*8])
    else $error("processor released early after peripheral release");

  chk_cpu_age: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cpuRstn) |-> stageAge_r == srseq_pkg::STAGE_GAP)
    else $error("processor release age differs from stage gap");

  chk_cpu_follows: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(periphRstn) && !reqFilt_r) ##1 (!reqFilt_r)[*8] ##1 (!reqFilt_r)[*7]
      |=> $rose(cpuRstn))
    else $error("processor not released 16 clocks after peripheral release");

  chk_filt_fall: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(reqFilt_r) |-> !$past(sync2_r, 1) && !$past(sync2_r, 4))
    else $error("filtered request fell without stable synchronised input");

  chk_sync_chain: assert property (@(posedge core_clk) disable iff (!rstn)
    sync2_r == $past(sync1_r))
    else $error("synchroniser second stage skipped a sample");

endmodule : srseq_top

// *** verif/srseq_board.sv ***
// board reset source model for the staged reset sequencer
// assumes the bench changes reqOn only at falling clock edges
module srseq_board (
  input wire logic reqOn,
  output logic boardRst
);
  timeunit 1ns;
  timeprecision 1ps;
  // high asks for a reset of the whole subsystem
  assign boardRst = reqOn;
endmodule : srseq_board

// *** verif/subsystem_reset_sequencer_tb.sv ***
// self-checking bench for srseq_top
// assumes a 2-stage sync and a 4-sample filter ahead of the sequencer
module subsystem_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reqOn = 1'b1;
  logic boardRst;
  logic busRstn;
  logic periphRstn;
  logic cpuRstn;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #12.5 core_clk = ~core_clk;
  srseq_board u_board (.reqOn(reqOn), .boardRst(boardRst));
  srseq_top u_dut (.core_clk(core_clk), .rstn(rstn), .boardRst(boardRst),
    .busRstn(busRstn), .periphRstn(periphRstn), .cpuRstn(cpuRstn));
  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // the run needs about 260 cycles; a hang is cut well past that
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_n(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_n
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // waits are bounded so a stuck output shows as a wrong count
  // bus release lags the board by 2 sync + 4 filter + 2 sequencer clocks
  task automatic check_release();
    int n;
    n = 0;
    while (busRstn !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    cmp_n(n, 8);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h4);
    n = 0;
    while (periphRstn !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    cmp_n(n, 16);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h6);
    n = 0;
    while (cpuRstn !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    cmp_n(n, 16);
  endtask : check_release
  task automatic t_power_up();
    tick(16);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h0);
    rstn = 1'b1;
    tick(20);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h0);
    reqOn = 1'b0;
    check_release();
  endtask : t_power_up
  // one-cycle and three-cycle pulses are both shorter than the filter accepts
  task automatic t_glitch();
    reqOn = 1'b1;
    tick(1);
    reqOn = 1'b0;
    tick(10);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h7);
    reqOn = 1'b1;
    tick(3);
    reqOn = 1'b0;
    tick(20);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h7);
  endtask : t_glitch
  task automatic t_restart();
    reqOn = 1'b1;
    tick(20);
    reqOn = 1'b0;
    tick(30);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h6);
    reqOn = 1'b1;
    tick(12);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h0);
    reqOn = 1'b0;
    check_release();
  endtask : t_restart
  // core reset in mid-run with the board quiet must replay the whole release
  task automatic t_mid_reset();
    rstn = 1'b0;
    tick(4);
    cmp({busRstn, periphRstn, cpuRstn}, 3'h0);
    rstn = 1'b1;
    check_release();
  endtask : t_mid_reset
  initial
  begin
    t_power_up();
    t_glitch();
    t_restart();
    t_mid_reset();
    test_done();
  end
endmodule : subsystem_reset_sequencer_tb
